//--- src/atbc_map.vh
`ifndef ATBC_MAP_VH
`define ATBC_MAP_VH
// ****************************************
// Configuration ports and indexes
// ****************************************
`define ATBC_PORT_INDEX 16'h0022
`define ATBC_PORT_DATA 16'h0023
`define ATBC_IDX_CPU_CLOCK 8'h60
`define ATBC_IDX_CMD_DELAY 8'h61
`define ATBC_IDX_WAIT_STATE 8'h62
// ****************************************
// Reset values
// ****************************************
`define ATBC_RST_INDEX 8'h00
`define ATBC_RST_CPU_CLOCK 8'h00
`define ATBC_RST_CMD_DELAY 8'h41
`define ATBC_RST_WAIT_STATE 8'h3c
// ****************************************
// Implemented bits per register
// ****************************************
`define ATBC_MASK_CPU_CLOCK 8'h01
`define ATBC_MASK_CMD_DELAY 8'hcf
`define ATBC_MASK_WAIT_STATE 8'h3f
// ****************************************
// Field positions
// ****************************************
`define ATBC_CD_IO_LSB 0
`define ATBC_CD_MEM_LSB 2
`define ATBC_CD_QUICK_OFF 6
`define ATBC_CD_HOLD 7
`define ATBC_WS_BCLK_LSB 0
`define ATBC_WS_8BIT_LSB 2
`define ATBC_WS_16BIT_LSB 4
// ****************************************
// Bus clock sources and modes
// ****************************************
`define ATBC_BCLK_HALF 2'h0
`define ATBC_BCLK_FULL 2'h1
`define ATBC_BCLK_EXT 2'h2
`define ATBC_MODE_NORMAL 2'h0
`define ATBC_MODE_QUICK 2'h1
`define ATBC_MODE_DELAYED 2'h2
`define ATBC_MODE_EXTERNAL 2'h3
// ****************************************
// Timing counts
// ****************************************
`define ATBC_WS8_BASE 3'h2
`define ATBC_HOLD_CYCLES 2'h2
`endif

//--- src/atbc_clkgen.v
`include "atbc_map.vh"
`default_nettype none
module atbc_clkgen (
   input wire core_clk,
   input wire reset_n,
   input wire [1:0] mode,
   input wire external_bus_clock_in,
   output wire bus_state_en,
   output wire sys_state_en,
   output reg system_half_clock
);
   // ****************************************
   // External clock synchroniser
   // ****************************************
   reg ext_s1_q;
   reg ext_s2_q;
   reg ext_s3_q;
   reg div_q;
   reg sys_phase_q;
   wire ext_rise;
   always @(posedge core_clk) begin
      if (!reset_n) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= external_bus_clock_in;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end
   assign ext_rise = ext_s2_q & ~ext_s3_q;
   // ****************************************
   // Dividers
   // ****************************************
   // Bus states: half rate, full rate or external edges
   assign bus_state_en = (mode == `ATBC_MODE_NORMAL) ? div_q :
                         (mode == `ATBC_MODE_EXTERNAL) ? ext_rise : 1'b1;
   // System clock is always the bus clock halved
   assign sys_state_en = bus_state_en & sys_phase_q;
   always @(posedge core_clk) begin
      if (!reset_n) begin
         div_q <= 1'b0;
         sys_phase_q <= 1'b0;
         system_half_clock <= 1'b0;
      end else begin
         div_q <= ~div_q;
         if (bus_state_en) begin
            sys_phase_q <= ~sys_phase_q;
            system_half_clock <= ~sys_phase_q;
         end
      end
   end
endmodule // atbc_clkgen
`default_nettype wire

//--- src/atbc_ctrl.v
`include "atbc_map.vh"
`default_nettype none
// Functional notes
// - Reset runs normal mode, bus /2, system /4
// - Normal: strobe and commands only for expansion
// - Default: one I/O command delay
// - Hold bit delays READY by one command state
// - Hold extension only in normal mode
// - Quick mode: bit6 zero, full-rate bus clock
// - Quick: strobe always, commands expansion only
// - Quick: action enable timing by direction
// - Delayed mode: bit6 set, full-rate bus clock
// - Delayed: strobe after sampling flag high
// - Delayed: pulse upper address latch enable
// - Count command delays and wait states
// - External clock source selects external mode
// - External: latch flag, resample on bus edge
// - External: detect command off, then READY
// - Flag low local, high to bus machine
// - Index config_index_select, data config_data_window
// - Reserved bits reset and read zero
// - Wait-state register at index 62H
// - Bits 1:0 select bus clock source
// - Wait-state fields for 8 and 16 bit
module atbc_ctrl (
   input wire core_clk,
   input wire reset_n,
   input wire [15:0] io_addr,
   input wire io_wr,
   input wire io_rd,
   input wire [7:0] io_wdata,
   output reg [7:0] io_rdata,
   output reg io_rvalid,
   input wire cycle_start,
   input wire cycle_write,
   input wire cycle_io,
   input wire cycle_16bit,
   input wire next_is_bus_write,
   input wire expansion_cycle_flag,
   input wire external_bus_clock_in,
   output reg cpu_addr_latch_strobe,
   output reg bus_addr_latch_strobe,
   output reg upper_addr_latch_enable,
   output reg action_code_enable,
   output reg bus_mem_read_cmd,
   output reg bus_mem_write_cmd,
   output reg bus_io_read_cmd,
   output reg bus_io_write_cmd,
   output reg cpu_ready_n,
   output wire bus_state_en,
   output wire sys_state_en,
   output wire system_half_clock,
   output reg [1:0] mode_q
);
   // ****************************************
   // Configuration registers
   // ****************************************
   reg [7:0] index_q;
   reg [7:0] cpu_clock_selector_q;
   reg [7:0] command_delay_control_q;
   reg [7:0] wait_state_bus_clock_select_q;
   reg [7:0] rd_d;
   wire idx_sel = io_addr == `ATBC_PORT_INDEX;
   wire dat_sel = io_addr == `ATBC_PORT_DATA;
   always @* begin
      rd_d = 8'h00;
      if (idx_sel) begin
         rd_d = index_q;
      end else if (dat_sel) begin
         case (index_q)
            `ATBC_IDX_CPU_CLOCK: rd_d = cpu_clock_selector_q;
            `ATBC_IDX_CMD_DELAY: rd_d = command_delay_control_q;
            `ATBC_IDX_WAIT_STATE: rd_d = wait_state_bus_clock_select_q;
            default: rd_d = 8'h00;
         endcase
      end
   end
   always @(posedge core_clk) begin
      if (!reset_n) begin
         index_q <= `ATBC_RST_INDEX;
         cpu_clock_selector_q <= `ATBC_RST_CPU_CLOCK;
         command_delay_control_q <= `ATBC_RST_CMD_DELAY;
         wait_state_bus_clock_select_q <= `ATBC_RST_WAIT_STATE;
         io_rdata <= 8'h00;
         io_rvalid <= 1'b0;
      end else begin
         io_rvalid <= io_rd;
         if (io_rd) begin
            io_rdata <= rd_d;
         end
         if (io_wr && idx_sel) begin
            index_q <= io_wdata;
         end
         // Reserved bits are masked, so they stay zero
         if (io_wr && dat_sel) begin
            case (index_q)
               `ATBC_IDX_CPU_CLOCK:
                  cpu_clock_selector_q <= io_wdata & `ATBC_MASK_CPU_CLOCK;
               `ATBC_IDX_CMD_DELAY:
                  command_delay_control_q <= io_wdata & `ATBC_MASK_CMD_DELAY;
               `ATBC_IDX_WAIT_STATE:
                  wait_state_bus_clock_select_q <=
                     io_wdata & `ATBC_MASK_WAIT_STATE;
               default: index_q <= index_q;
            endcase
         end
      end
   end
   // ****************************************
   // Mode decode
   // ****************************************
   wire [1:0] bclk_sel = wait_state_bus_clock_select_q[`ATBC_WS_BCLK_LSB+1:
                                                       `ATBC_WS_BCLK_LSB];
   wire quick_off = command_delay_control_q[`ATBC_CD_QUICK_OFF];
   reg [1:0] mode_d;
   always @* begin
      case (bclk_sel)
         `ATBC_BCLK_EXT: mode_d = `ATBC_MODE_EXTERNAL;
         `ATBC_BCLK_FULL: mode_d = quick_off ? `ATBC_MODE_DELAYED :
                                               `ATBC_MODE_QUICK;
         default: mode_d = `ATBC_MODE_NORMAL;
      endcase
   end
   atbc_clkgen u_clkgen (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .mode(mode_q),
      .external_bus_clock_in(external_bus_clock_in),
      .bus_state_en(bus_state_en),
      .sys_state_en(sys_state_en),
      .system_half_clock(system_half_clock)
   );
   // ****************************************
   // Cycle state machine
   // ****************************************
   localparam S_IDLE = 3'h0;
   localparam S_SAMPLE = 3'h1;
   localparam S_BUSWAIT = 3'h2;
   localparam S_LAG = 3'h3;
   localparam S_DELAY = 3'h4;
   localparam S_CMD = 3'h5;
   localparam S_HOLD = 3'h6;
   localparam S_READY = 3'h7;
   reg [2:0] state_q;
   reg [2:0] count_q;
   reg [1:0] hold_q;
   reg wr_q;
   reg io_q;
   reg w16_q;
   reg flag_latch_q;
   wire quick = mode_q == `ATBC_MODE_QUICK;
   wire delayed = mode_q == `ATBC_MODE_DELAYED;
   wire external = mode_q == `ATBC_MODE_EXTERNAL;
   wire hold_on = command_delay_control_q[`ATBC_CD_HOLD] &
                  (mode_q == `ATBC_MODE_NORMAL);
   wire [1:0] cd_io = command_delay_control_q[`ATBC_CD_IO_LSB+1:
                                              `ATBC_CD_IO_LSB];
   wire [1:0] cd_mem = command_delay_control_q[`ATBC_CD_MEM_LSB+1:
                                               `ATBC_CD_MEM_LSB];
   wire [1:0] ws8 = wait_state_bus_clock_select_q[`ATBC_WS_8BIT_LSB+1:
                                                  `ATBC_WS_8BIT_LSB];
   wire [1:0] ws16 = wait_state_bus_clock_select_q[`ATBC_WS_16BIT_LSB+1:
                                                   `ATBC_WS_16BIT_LSB];
   // 8-bit cycles start at two wait states, 16-bit at zero
   wire [2:0] ws_count = w16_q ? {1'b0, ws16} : ({1'b0, ws8} + `ATBC_WS8_BASE);
   wire [2:0] cd_count = {1'b0, io_q ? cd_io : cd_mem};
   wire cmd_any = bus_mem_read_cmd | bus_mem_write_cmd |
                  bus_io_read_cmd | bus_io_write_cmd;
   always @(posedge core_clk) begin
      if (!reset_n) begin
         mode_q <= `ATBC_MODE_NORMAL;
         state_q <= S_IDLE;
         count_q <= 3'h0;
         hold_q <= 2'h0;
         wr_q <= 1'b0;
         io_q <= 1'b0;
         w16_q <= 1'b0;
         flag_latch_q <= 1'b0;
         cpu_addr_latch_strobe <= 1'b0;
         bus_addr_latch_strobe <= 1'b0;
         upper_addr_latch_enable <= 1'b0;
         action_code_enable <= 1'b0;
         bus_mem_read_cmd <= 1'b0;
         bus_mem_write_cmd <= 1'b0;
         bus_io_read_cmd <= 1'b0;
         bus_io_write_cmd <= 1'b0;
         cpu_ready_n <= 1'b1;
      end else begin
         cpu_addr_latch_strobe <= 1'b0;
         cpu_ready_n <= 1'b1;
         // Mode only changes between cycles, never mid-transfer
         if (state_q == S_IDLE) begin
            mode_q <= mode_d;
         end
         case (state_q)
            S_IDLE: begin
               if (cycle_start) begin
                  cpu_addr_latch_strobe <= 1'b1;
                  bus_addr_latch_strobe <= quick;
                  wr_q <= cycle_write;
                  io_q <= cycle_io;
                  w16_q <= cycle_16bit;
                  state_q <= S_SAMPLE;
               end
            end
            S_SAMPLE: begin
               bus_addr_latch_strobe <= 1'b0;
               if (!expansion_cycle_flag) begin
                  // Local cycle: no commands in any mode
                  state_q <= S_READY;
               end else begin
                  flag_latch_q <= 1'b1;
                  // Write data codes lead the command by a state
                  action_code_enable <= wr_q;
                  state_q <= S_BUSWAIT;
               end
            end
            S_BUSWAIT: begin
               // External mode waits for the next bus rising edge
               if (bus_state_en && flag_latch_q) begin
                  flag_latch_q <= 1'b0;
                  if (delayed) begin
                     upper_addr_latch_enable <= 1'b1;
                     state_q <= S_LAG;
                  end else begin
                     bus_addr_latch_strobe <= ~quick;
                     count_q <= cd_count;
                     state_q <= S_DELAY;
                  end
               end
            end
            S_LAG: begin
               if (bus_state_en) begin
                  // Strobe one bus state after the flag sample
                  bus_addr_latch_strobe <= 1'b1;
                  count_q <= cd_count;
                  state_q <= S_DELAY;
               end
            end
            S_DELAY: begin
               if (bus_state_en) begin
                  bus_addr_latch_strobe <= 1'b0;
                  upper_addr_latch_enable <= 1'b0;
                  if (count_q == 3'h0) begin
                     bus_mem_read_cmd <= ~io_q & ~wr_q;
                     bus_mem_write_cmd <= ~io_q & wr_q;
                     bus_io_read_cmd <= io_q & ~wr_q;
                     bus_io_write_cmd <= io_q & wr_q;
                     action_code_enable <= 1'b1;
                     count_q <= ws_count;
                     state_q <= S_CMD;
                  end else begin
                     count_q <= count_q - 3'h1;
                  end
               end
            end
            S_CMD: begin
               if (bus_state_en) begin
                  if (count_q == 3'h0) begin
                     bus_mem_read_cmd <= 1'b0;
                     bus_mem_write_cmd <= 1'b0;
                     bus_io_read_cmd <= 1'b0;
                     bus_io_write_cmd <= 1'b0;
                     hold_q <= `ATBC_HOLD_CYCLES;
                     state_q <= S_HOLD;
                  end else begin
                     count_q <= count_q - 3'h1;
                  end
               end
            end
            S_HOLD: begin
               // Command seen inactive on a fast-clock edge
               if (external && cmd_any) begin
                  state_q <= S_HOLD;
               end else if (hold_on && hold_q != 2'h0) begin
                  hold_q <= hold_q - 2'h1;
               end else begin
                  state_q <= S_READY;
               end
            end
            S_READY: begin
               cpu_ready_n <= 1'b0;
               // Codes stay on into a following bus write
               action_code_enable <= action_code_enable & next_is_bus_write;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule // atbc_ctrl
`default_nettype wire

//--- bench/atbc_ctrl_asserts.sv
`include "atbc_map.vh"
`default_nettype none
// ****************************************
// Port checker for the cycle controller
// ****************************************
module atbc_chk (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic io_rd,
   input wire logic io_rvalid,
   input wire logic cycle_start,
   input wire logic expansion_cycle_flag,
   input wire logic cpu_addr_latch_strobe,
   input wire logic bus_addr_latch_strobe,
   input wire logic upper_addr_latch_enable,
   input wire logic bus_mem_read_cmd,
   input wire logic bus_mem_write_cmd,
   input wire logic bus_io_read_cmd,
   input wire logic bus_io_write_cmd,
   input wire logic cpu_ready_n,
   input wire logic bus_state_en,
   input wire logic sys_state_en,
   input wire logic system_half_clock,
   input wire logic [1:0] mode_q
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [3:0] cmds;
   wire logic local_c;
   assign cmds = {bus_mem_read_cmd, bus_mem_write_cmd, bus_io_read_cmd,
      bus_io_write_cmd};
   assign local_c = cpu_addr_latch_strobe && !expansion_cycle_flag;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   read_answer_a: assert property (
      1'b1 |=> io_rvalid == $past(io_rd))
      else $error("read answer not one cycle after the read");
   strobe_cause_a: assert property (
      cpu_addr_latch_strobe |-> $past(cycle_start))
      else $error("cpu strobe without a cycle start");
   local_ready_a: assert property (
      local_c |-> ##2 !cpu_ready_n && cmds == 4'h0)
      else $error("local cycle not ended two cycles after start");
   local_ale_a: assert property (
      local_c |-> bus_addr_latch_strobe == (mode_q == `ATBC_MODE_QUICK))
      else $error("bus strobe wrong on a local cycle");
   ready_pulse_a: assert property (
      !cpu_ready_n |=> cpu_ready_n)
      else $error("ready held longer than one cycle");
   cmd_single_a: assert property ($onehot0(cmds))
      else $error("two bus commands at once");
   normal_rate_a: assert property (
      mode_q == `ATBC_MODE_NORMAL && bus_state_en ##1
      mode_q == `ATBC_MODE_NORMAL |-> !bus_state_en)
      else $error("normal bus state rate not half");
   fast_rate_a: assert property (
      mode_q == `ATBC_MODE_QUICK || mode_q == `ATBC_MODE_DELAYED |->
      bus_state_en)
      else $error("full-rate bus state missing");
   half_toggle_a: assert property (
      bus_state_en |=> system_half_clock != $past(system_half_clock))
      else $error("system clock did not toggle on a bus state");
   sys_rate_a: assert property (
      sys_state_en |-> bus_state_en && system_half_clock)
      else $error("system state not on every second bus state");
   upper_mode_a: assert property (
      upper_addr_latch_enable |-> mode_q == `ATBC_MODE_DELAYED)
      else $error("upper latch enable outside delayed mode");
   ext_ready_a: assert property (
      mode_q == `ATBC_MODE_EXTERNAL && !cpu_ready_n |->
      cmds == 4'h0 && $past(cmds) == 4'h0)
      else $error("external ready before commands went inactive");
   cover property (local_c ##2 !cpu_ready_n);
   cover property (bus_addr_latch_strobe && mode_q == `ATBC_MODE_QUICK);
   cover property (upper_addr_latch_enable);
   cover property (mode_q == `ATBC_MODE_EXTERNAL && !cpu_ready_n);
endmodule // atbc_chk
bind atbc_ctrl atbc_chk i_chk (.core_clk, .reset_n, .io_rd, .io_rvalid,
   .cycle_start, .expansion_cycle_flag, .cpu_addr_latch_strobe,
   .bus_addr_latch_strobe, .upper_addr_latch_enable, .bus_mem_read_cmd,
   .bus_mem_write_cmd, .bus_io_read_cmd, .bus_io_write_cmd, .cpu_ready_n,
   .bus_state_en, .sys_state_en, .system_half_clock, .mode_q);
`default_nettype wire

//--- bench/atbc_exp_card.sv
`default_nettype none
// ****************************************
// Expansion card: own bus clock, command count
// ****************************************
module atbc_exp_card (
   input wire logic [3:0] cmds,
   output logic external_bus_clock_in,
   output int cmd_pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic any_cmd;
   assign any_cmd = |cmds;
   // Odd half period keeps the card clock drifting against the core
   initial begin
      external_bus_clock_in = 1'b0;
      forever #31 external_bus_clock_in = ~external_bus_clock_in;
   end
   initial cmd_pulses = 0;
   always @(posedge any_cmd) cmd_pulses++;
endmodule // atbc_exp_card
`default_nettype wire

//--- bench/atbc_ctrl_bench.sv
`include "atbc_map.vh"
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
// ****************************************
// Bench for the bus cycle controller
// ****************************************
module atbc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, reset_n, io_wr, io_rd, io_rvalid, cycle_start, cycle_write;
   logic cycle_io, cycle_16bit, next_is_bus_write, expansion_cycle_flag;
   logic external_bus_clock_in, cpu_addr_latch_strobe, bus_addr_latch_strobe;
   logic upper_addr_latch_enable, action_code_enable, bus_mem_read_cmd;
   logic bus_mem_write_cmd, bus_io_read_cmd, bus_io_write_cmd, cpu_ready_n;
   logic bus_state_en, sys_state_en, system_half_clock, action_code_enable_after;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata;
   logic [1:0] mode_q;
   logic [5:0] seen;
   int bad_count, check_count, la, lb, lc, pulses;
   atbc_ctrl i_dut (.core_clk, .reset_n, .io_addr, .io_wr, .io_rd, .io_wdata,
      .io_rdata, .io_rvalid, .cycle_start, .cycle_write, .cycle_io,
      .cycle_16bit, .next_is_bus_write, .expansion_cycle_flag,
      .external_bus_clock_in, .cpu_addr_latch_strobe, .bus_addr_latch_strobe,
      .upper_addr_latch_enable, .action_code_enable, .bus_mem_read_cmd,
      .bus_mem_write_cmd, .bus_io_read_cmd, .bus_io_write_cmd, .cpu_ready_n,
      .bus_state_en, .sys_state_en, .system_half_clock, .mode_q);
   atbc_exp_card i_card (.cmds({bus_mem_read_cmd, bus_mem_write_cmd,
      bus_io_read_cmd, bus_io_write_cmd}), .external_bus_clock_in,
      .cmd_pulses(pulses));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge core_clk);
      io_wr = 1'b0;
   endtask
   task automatic bus_rd(input logic [15:0] a, input logic [7:0] e);
      int n;
      @(negedge core_clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge core_clk);
      io_rd = 1'b0;
      n = 0;
      while (io_rvalid !== 1'b1 && n < 3) begin
         @(negedge core_clk);
         n++;
      end
      `CHK(io_rdata, e)
   endtask
   // Index is rewritten before every data access, data written unmasked
   task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
      bus_wr(`ATBC_PORT_INDEX, idx);
      bus_wr(`ATBC_PORT_DATA, d);
   endtask
   task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] e);
      bus_wr(`ATBC_PORT_INDEX, idx);
      bus_rd(`ATBC_PORT_DATA, e);
   endtask
   task automatic set_mode(input logic [7:0] cd, input logic [7:0] ws,
      input logic [1:0] m);
      cfg(`ATBC_IDX_CMD_DELAY, cd);
      cfg(`ATBC_IDX_WAIT_STATE, ws);
      repeat (3) @(negedge core_clk);
      `CHK(mode_q, m)
   endtask
   // One CPU cycle; length counts cycles from the start edge to ready
   task automatic run(input logic wr, io, b16, fl, output int len);
      // Start on a bus state so bus edges fall at a fixed offset
      @(negedge core_clk);
      while (bus_state_en !== 1'b1) begin
         @(negedge core_clk);
      end
      {cycle_write, cycle_io, cycle_16bit} = {wr, io, b16};
      expansion_cycle_flag = fl;
      cycle_start = 1'b1;
      @(negedge core_clk);
      cycle_start = 1'b0;
      len = 0;
      seen = 6'h00;
      while (cpu_ready_n !== 1'b0 && len < 400) begin
         seen |= {upper_addr_latch_enable, bus_addr_latch_strobe,
            bus_mem_read_cmd, bus_mem_write_cmd, bus_io_read_cmd,
            bus_io_write_cmd};
         @(negedge core_clk);
         len++;
      end
      `CHK(cpu_ready_n, 1'b0)
      @(negedge core_clk);
      action_code_enable_after = action_code_enable;
      expansion_cycle_flag = 1'b0;
   endtask
   task automatic reg_tests();
      cfg_rd(`ATBC_IDX_CPU_CLOCK, 8'h00);
      cfg_rd(`ATBC_IDX_CMD_DELAY, 8'h41);
      cfg_rd(`ATBC_IDX_WAIT_STATE, 8'h3c);
      bus_rd(16'h0024, 8'h00);
      bus_rd(`ATBC_PORT_INDEX, `ATBC_IDX_WAIT_STATE);
      bus_rd(`ATBC_PORT_DATA, 8'h3c);
      cfg_rd(8'h70, 8'h00);
      cfg(`ATBC_IDX_CPU_CLOCK, 8'hff);
      cfg_rd(`ATBC_IDX_CPU_CLOCK, 8'h01);
      set_mode(8'h41, 8'hff, `ATBC_MODE_NORMAL);
      cfg_rd(`ATBC_IDX_WAIT_STATE, 8'h3f);
   endtask
   task automatic normal_tests();
      set_mode(8'h41, 8'h00, `ATBC_MODE_NORMAL);
      run(1'b0, 1'b0, 1'b1, 1'b0, la);
      `CHK(la, 2)
      `CHK(seen, 6'h00)
      run(1'b1, 1'b1, 1'b0, 1'b1, la);
      `CHK(seen[4:0], 5'h11)
      run(1'b0, 1'b0, 1'b1, 1'b1, la);
      cfg(`ATBC_IDX_CMD_DELAY, 8'hc1);
      run(1'b0, 1'b0, 1'b1, 1'b1, lb);
      `CHK(lb - la, 2)
   endtask
   task automatic quick_tests();
      set_mode(8'h81, 8'h01, `ATBC_MODE_QUICK);
      run(1'b0, 1'b0, 1'b1, 1'b0, la);
      `CHK(seen, 6'h10)
      run(1'b0, 1'b0, 1'b1, 1'b1, la);
      `CHK(seen[3:0], 4'h8)
      cfg(`ATBC_IDX_CMD_DELAY, 8'h01);
      run(1'b0, 1'b0, 1'b1, 1'b1, lb);
      `CHK(lb, la)
      cfg(`ATBC_IDX_CMD_DELAY, 8'h09);
      run(1'b0, 1'b0, 1'b1, 1'b1, lc);
      `CHK(lc - lb, 2)
      set_mode(8'h01, 8'h31, `ATBC_MODE_QUICK);
      run(1'b0, 1'b0, 1'b1, 1'b1, lc);
      `CHK(lc - lb, 3)
      next_is_bus_write = 1'b1;
      run(1'b1, 1'b0, 1'b1, 1'b1, la);
      `CHK(action_code_enable_after, 1'b1)
      next_is_bus_write = 1'b0;
      run(1'b1, 1'b0, 1'b1, 1'b1, la);
      `CHK(action_code_enable_after, 1'b0)
   endtask
   task automatic slow_tests();
      set_mode(8'h41, 8'h01, `ATBC_MODE_DELAYED);
      run(1'b0, 1'b0, 1'b1, 1'b0, la);
      `CHK(seen, 6'h00)
      run(1'b1, 1'b1, 1'b1, 1'b1, la);
      `CHK(seen[5], 1'b1)
      set_mode(8'h41, 8'h02, `ATBC_MODE_EXTERNAL);
      lb = pulses;
      run(1'b1, 1'b1, 1'b1, 1'b1, la);
      `CHK(pulses - lb, 1)
      `CHK(seen[0], 1'b1)
      set_mode(8'h41, 8'h00, `ATBC_MODE_NORMAL);
   endtask
   initial begin
      {reset_n, io_wr, io_rd, cycle_start, cycle_write, cycle_io} = 6'h00;
      {cycle_16bit, next_is_bus_write, expansion_cycle_flag} = 3'h0;
      io_addr = 16'h0000;
      io_wdata = 8'h00;
      bad_count = 0;
      check_count = 0;
      repeat (10) @(negedge core_clk);
      reset_n = 1'b1;
      `CHK(mode_q, `ATBC_MODE_NORMAL)
      `CHK(cpu_ready_n, 1'b1)
      reg_tests();
      normal_tests();
      quick_tests();
      slow_tests();
      print_verdict();
   end
   // Whole run is a few hundred cycles; this span is far beyond it
   initial begin
      #(25 * 40000);
      bad_count++;
      print_verdict();
   end
endmodule // atbc_ctrl_bench
`default_nettype wire
